// >>> pst_level.sv
// Pick-up comparator with fixed reset hysteresis
`timescale 1ns/1ps
module pst_level (
  input  wire logic                      under_in,
  input  wire logic                      picked_in,
  input  wire logic [pst_pkg::MAG_W-1:0] level_in,
  input  wire logic [pst_pkg::MAG_W-1:0] measured_magnitude_in,
  output logic                           pickup_out
);
  import pst_pkg::*;

  // Scaled compare avoids a divider: 100*m against 97*level (over) or 103*level (under)
  wire [MAG_W+7:0] mag_x100  = (MAG_W+8)'(measured_magnitude_in) * (MAG_W+8)'(RST_DEN);
  wire [MAG_W+7:0] lvl_x100  = (MAG_W+8)'(level_in) * (MAG_W+8)'(RST_DEN);
  wire [MAG_W+7:0] lvl_x97   = (MAG_W+8)'(level_in) * (MAG_W+8)'(RST_NUM);
  wire [MAG_W+7:0] lvl_x103  = lvl_x100 + (lvl_x100 - lvl_x97);
  wire             over_on   = measured_magnitude_in > level_in;
  wire             under_on  = measured_magnitude_in < level_in;
  wire             over_hold = mag_x100 > lvl_x97;
  wire             under_hold = mag_x100 < lvl_x103;

  assign pickup_out = under_in ? (picked_in ? under_hold : under_on)
                               : (picked_in ? over_hold : over_on);

endmodule : pst_level

// >>> pst_meas_model.sv
// Measurement and blocking matrix model
`timescale 1ns/1ps
module pst_meas_model (
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic [pst_pkg::MAG_W-1:0] mag_req_in,
  input  wire logic                      blk_req_in,
  output logic      [pst_pkg::MAG_W-1:0] mag_out,
  output logic                           blk_out,
  output logic      [pst_pkg::DLY_W-1:0] inv_dly_out
);
  import pst_pkg::*;
  // One clock of latency, far inside 5 ms
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mag_out <= MAG_MIN;
      blk_out <= 1'h0;
    end else begin
      mag_out <= (mag_req_in < MAG_MIN) ? MAG_MIN : mag_req_in;
      blk_out <= blk_req_in;
    end
  end
  // Curve math lives outside; fixed arbitrary delay
  assign inv_dly_out = 19'h00004;
endmodule : pst_meas_model

// >>> pst_monitor.sv
// Checker for the protection stage outputs
`timescale 1ns/1ps
module pst_monitor (
  input wire logic                clk_in,
  input wire logic                sys_rst_in,
  input wire logic                cycle_tick_out,
  input wire logic                start_out,
  input wire logic                trip_out,
  input wire logic                block_indication_out,
  input wire logic                hmi_notice_out,
  input wire logic                event_valid_out,
  input wire pst_pkg::pst_event_t event_out,
  input wire logic                curve_ieee_out,
  input wire logic                inverse_time_mode_out
);
  import pst_pkg::*;
  logic [CYC_CNT_W-1:0] cnt_ff;
  logic                 armed_ff;
  // First tick after reset has no reference
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_ff   <= '0;
      armed_ff <= 1'h0;
    end else begin
      cnt_ff   <= cycle_tick_out ? '0 : cnt_ff + 18'h1;
      armed_ff <= armed_ff | cycle_tick_out;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Forcing stays off in the bench
  output_timing_a: assert property (
    $changed({start_out, trip_out, block_indication_out}) |-> $past(cycle_tick_out, 2))
    else $error("stage outputs moved off the evaluation edge");
  tick_period_a: assert property (
    cycle_tick_out && armed_ff |-> cnt_ff == CYCLE_LAST)
    else $error("program cycle length wrong");
  block_indication_excl_a: assert property (
    block_indication_out |-> !start_out && !trip_out)
    else $error("start or trip while block_indication");
  trip_start_a: assert property (
    trip_out |-> start_out)
    else $error("trip without start");
  notice_pulse_a: assert property (
    hmi_notice_out |-> event_valid_out ##1 !hmi_notice_out)
    else $error("notice pulse malformed");
  // Notice pulses on the state edge, one clock ahead of the indication
  notice_block_a: assert property (
    $rose(block_indication_out) |-> $past(hmi_notice_out))
    else $error("no notice for blocking");
  event_hold_a: assert property (
    !event_valid_out |-> $stable(event_out))
    else $error("event record changed without pulse");
  curve_gate_a: assert property (
    curve_ieee_out |-> inverse_time_mode_out)
    else $error("curve series active outside inverse mode");
endmodule : pst_monitor

// >>> pst_pkg.sv
// Package for the protection stage pick-up and timing core
package pst_pkg;

  // Processing clock and program cycle
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CYCLE_US        = 5000;
  localparam int unsigned CYCLE_CLKS      = (CLK_HZ / 1_000_000) * CYCLE_US;
  localparam int unsigned CYC_CNT_W       = 18;
  localparam logic [CYC_CNT_W-1:0] CYCLE_LAST = CYC_CNT_W'(CYCLE_CLKS - 1);

  // Magnitudes: unsigned milli-units (milliampere for current)
  localparam int unsigned MAG_W           = 18;
  localparam logic [MAG_W-1:0] MAG_MIN    = 18'h00001;
  localparam logic [MAG_W-1:0] MAG_MAX    = 18'h3d090;
  localparam logic [MAG_W-1:0] NOM_MIN    = 18'h000c8;
  localparam logic [MAG_W-1:0] NOM_MAX    = 18'h02710;
  localparam logic [MAG_W-1:0] NOM_RST    = 18'h003e8;

  // Pick-up units
  localparam logic [1:0] UNIT_ABS         = 2'h0;
  localparam logic [1:0] UNIT_PU          = 2'h1;
  localparam logic [1:0] UNIT_PCT         = 2'h2;
  localparam int unsigned PU_FRAC         = 1000;
  localparam int unsigned PCT_FRAC        = 100000;

  // Reset ratio 97 %
  localparam int unsigned RST_NUM         = 97;
  localparam int unsigned RST_DEN         = 100;

  // Delay setting, steps of 5 ms up to 1800 s
  localparam int unsigned DLY_STEP_MS     = 5;
  localparam int unsigned DLY_W           = 19;
  localparam logic [DLY_W-1:0] DLY_MAX    = 19'h57e40;
  localparam logic [DLY_W-1:0] DLY_RST    = 19'h00008;

  // Register map (word index)
  localparam int unsigned ADDR_W          = 4;
  localparam logic [ADDR_W-1:0] A_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] A_PICKUP  = 4'h1;
  localparam logic [ADDR_W-1:0] A_NOMINAL = 4'h2;
  localparam logic [ADDR_W-1:0] A_DELAY   = 4'h3;
  localparam logic [ADDR_W-1:0] A_INVDLY  = 4'h4;
  localparam logic [ADDR_W-1:0] A_STATUS  = 4'h5;
  localparam logic [ADDR_W-1:0] A_EVCNT   = 4'h6;

  // Control register bits
  localparam int unsigned C_UNDER  = 0;
  localparam int unsigned C_INV    = 1;
  localparam int unsigned C_IEEE   = 2;
  localparam int unsigned C_FEN    = 3;
  localparam int unsigned C_FSTART = 4;
  localparam int unsigned C_FTRIP  = 5;
  localparam int unsigned C_UNIT   = 6;
  localparam int unsigned CTRL_W   = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

  typedef enum logic [1:0] {
    PST_IDLE    = 2'b00,
    PST_START   = 2'b01,
    PST_TRIP    = 2'b11,
    PST_BLOCK_INDICATION = 2'b10
  } pst_state_t;

  typedef struct packed {
    logic             start;
    logic             trip;
    logic             block_indication;
    logic             picked;
  } pst_status_t;

  typedef struct packed {
    logic [MAG_W-1:0] magnitude;
    logic [1:0]       fault_type;
  } pst_event_t;

endpackage : pst_pkg

// >>> pst_stage.sv
// Protection stage core: pick-up, blocking and trip timing
//
// Functional notes
// - Pick-up asserts when magnitude passes level in set over/under direction.
// - Level given absolute, per unit or percent; acts as maximum or minimum.
// - Release only after magnitude returns past 97 % of the level; under direction releases past 103 %.
// - Blocking input sampled once at the start of each program cycle.
// - Pick-up without blocking raises start and begins trip timing.
// - Pick-up with blocking raises block_indication only; no timing or trip.
// - Blocking during start drops start and runs release as if reset.
// - Each blocking raises display notice and event with magnitude, fault type.
// - Instantaneous mode trips in the same cycle as start.
// - Definite time trips after fixed delay while pick-up stays.
// - Inverse time delay depends on level and magnitude per curve.
// - Inverse mode minimum delay floors the trip time; zero disables.
// - Delay type selects definite or inverse, default definite.
// - Definite delay in 5 ms steps, default 40 ms.
// - Zero delay is instantaneous; nonzero gives delayed operation.
// - Curve series IEC or IEEE, default IEC, only in inverse mode.
// - Nominal current settable 0.2 to 10 A for per-unit scaling.
// - Measured currents handled from 0.001 A to 250 A.
// - Forcing of start or trip only when enabled, disabled by default.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module pst_stage (
  input  wire logic                        clk_in,
  input  wire logic                        sys_rst_in,
  input  wire logic [pst_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [31:0]                 wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [31:0]                 rdata_out,
  input  wire logic [pst_pkg::MAG_W-1:0]   measured_magnitude_in,
  input  wire logic [1:0]                  fault_type_in,
  input  wire logic                        block_in,
  input  wire logic [pst_pkg::DLY_W-1:0]   inverse_delay_in,
  output logic                             curve_ieee_out,
  output logic                             inverse_time_mode_out,
  output logic                             cycle_tick_out,
  output logic                             start_out,
  output logic                             trip_out,
  output logic                             block_indication_out,
  output logic                             hmi_notice_out,
  output logic                             event_valid_out,
  output pst_pkg::pst_event_t              event_out
);
  import pst_pkg::*;

  // Settings
  logic [CTRL_W-1:0] ctrl_ff;
  logic [MAG_W-1:0]  pickup_level_ff;
  logic [MAG_W-1:0]  nominal_ff;
  logic [DLY_W-1:0]  delay_ff;
  logic [DLY_W-1:0]  inv_dly_ff;

  // Cycle machinery
  logic [CYC_CNT_W-1:0] cyc_cnt_ff;
  logic                 block_smp_ff;
  logic                 picked_ff;
  logic [DLY_W-1:0]     timer_ff;
  logic [15:0]          evcnt_ff;
  pst_state_t           state_ff;
  pst_state_t           nxt_state;
  pst_event_t           event_ff;
  logic                 event_valid_ff;
  logic                 hmi_ff;
  logic                 trip_ff;
  logic                 start_ff;
  logic                 blk_ff;
  logic [31:0]          rdata_ff;

  wire cycle_tick = cyc_cnt_ff == CYCLE_LAST;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cyc_cnt_ff <= '0;
    end else begin
      cyc_cnt_ff <= cycle_tick ? '0 : cyc_cnt_ff + 1'b1;
    end
  end

  // Register writes
  wire wr_ctrl  = wr_in && addr_in == A_CTRL;
  wire wr_pick  = wr_in && addr_in == A_PICKUP;
  wire wr_nom   = wr_in && addr_in == A_NOMINAL;
  wire wr_dly   = wr_in && addr_in == A_DELAY;
  wire wr_inv   = wr_in && addr_in == A_INVDLY;

  wire [MAG_W-1:0] wr_mag    = wdata_in[MAG_W-1:0];
  wire [MAG_W-1:0] pick_clip = wr_mag < MAG_MIN ? MAG_MIN : (wr_mag > MAG_MAX ? MAG_MAX : wr_mag);
  wire [MAG_W-1:0] nom_clip  = wr_mag < NOM_MIN ? NOM_MIN : (wr_mag > NOM_MAX ? NOM_MAX : wr_mag);
  wire [DLY_W-1:0] wr_dlyv   = wdata_in[DLY_W-1:0];
  wire [DLY_W-1:0] dly_clip  = wr_dlyv > DLY_MAX ? DLY_MAX : wr_dlyv;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= wdata_in[CTRL_W-1:0];
    end
  end

  // Highest level after reset keeps an unset stage quiet
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pickup_level_ff <= MAG_MAX;
    end else if (wr_pick) begin
      pickup_level_ff <= pick_clip;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      nominal_ff <= NOM_RST;
    end else if (wr_nom) begin
      nominal_ff <= nom_clip;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      delay_ff <= DLY_RST;
    end else if (wr_dly) begin
      delay_ff <= dly_clip;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      inv_dly_ff <= '0;
    end else if (wr_inv) begin
      inv_dly_ff <= wdata_in[DLY_W-1:0];
    end
  end

  wire       under     = ctrl_ff[C_UNDER];
  wire       inv_mode  = ctrl_ff[C_INV];
  wire       ieee      = ctrl_ff[C_IEEE] && inv_mode;
  wire       force_st  = ctrl_ff[C_FEN] && ctrl_ff[C_FSTART];
  wire       force_tr  = ctrl_ff[C_FEN] && ctrl_ff[C_FTRIP];
  wire [1:0] unit      = ctrl_ff[C_UNIT +: 2];

  wire [2*MAG_W-1:0] lvl_prod = pickup_level_ff * nominal_ff;
  wire [2*MAG_W-1:0] lvl_pu   = lvl_prod / (2*MAG_W)'(PU_FRAC);
  wire [2*MAG_W-1:0] lvl_pct  = lvl_prod / (2*MAG_W)'(PCT_FRAC);
  wire [2*MAG_W-1:0] lvl_sel  = unit == UNIT_PU  ? lvl_pu  :
                                unit == UNIT_PCT ? lvl_pct :
                                (2*MAG_W)'(pickup_level_ff);
  wire [MAG_W-1:0]   lvl_eff  = lvl_sel > (2*MAG_W)'(MAG_MAX) ? MAG_MAX : lvl_sel[MAG_W-1:0];

  wire pickup_now;
  pst_level u_level (
    .under_in              (under),
    .picked_in             (picked_ff),
    .level_in              (lvl_eff),
    .measured_magnitude_in (measured_magnitude_in),
    .pickup_out            (pickup_now)
  );

  // Trip delay in 5 ms ticks
  // Inverse delay from curve
  wire [DLY_W-1:0] inv_floor = inverse_delay_in < inv_dly_ff ? inv_dly_ff : inverse_delay_in;
  wire [DLY_W-1:0] trip_dly  = inv_mode ? inv_floor : delay_ff;
  wire             instant   = trip_dly == '0;
  // Timer counts in cycles already spent; the expiry compare uses the next count
  wire [DLY_W-1:0] timer_inc = timer_ff + 1'b1;
  wire             expire    = instant || timer_inc >= trip_dly;
  wire             blk       = block_smp_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PST_IDLE: begin
        if (pickup_now && blk) nxt_state = PST_BLOCK_INDICATION;
        else if (pickup_now && instant) nxt_state = PST_TRIP;
        else if (pickup_now) nxt_state = PST_START;
      end
      PST_START: begin
        if (blk) nxt_state = PST_BLOCK_INDICATION;
        else if (!pickup_now) nxt_state = PST_IDLE;
        else if (expire) nxt_state = PST_TRIP;
      end
      PST_TRIP: begin
        if (blk) nxt_state = PST_BLOCK_INDICATION;
        else if (!pickup_now) nxt_state = PST_IDLE;
      end
      PST_BLOCK_INDICATION: begin
        if (!pickup_now) nxt_state = PST_IDLE;
        else if (!blk) nxt_state = instant ? PST_TRIP : PST_START;
      end
      default: nxt_state = PST_IDLE;
    endcase
  end

  wire new_block = (nxt_state == PST_BLOCK_INDICATION) && (state_ff != PST_BLOCK_INDICATION);

  // Sample at cycle boundary
  // One sample per cycle keeps a late edge out of this decision
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      block_smp_ff <= 1'b0;
    end else if (cyc_cnt_ff == '0) begin
      block_smp_ff <= block_in;
    end
  end

  // Stage evaluated once per program cycle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_ff  <= PST_IDLE;
      picked_ff <= 1'b0;
    end else if (cycle_tick) begin
      state_ff  <= nxt_state;
      picked_ff <= pickup_now;
    end
  end

  // Timer restarts from zero
  // Leaving block_indication also starts timing afresh
  wire keep_timing = nxt_state == PST_START && state_ff == PST_START;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      timer_ff <= '0;
    end else if (cycle_tick) begin
      timer_ff <= keep_timing ? timer_inc : '0;
    end
  end

  wire log_block = cycle_tick && new_block;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      event_valid_ff <= 1'b0;
      hmi_ff         <= 1'b0;
    end else begin
      event_valid_ff <= log_block;
      hmi_ff         <= log_block;
    end
  end

  // Record held until the next blocking
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      event_ff <= '0;
    end else if (log_block) begin
      event_ff <= '{magnitude: measured_magnitude_in, fault_type: fault_type_in};
    end
  end

  // Count wraps; software compares with its last read
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      evcnt_ff <= '0;
    end else if (log_block) begin
      evcnt_ff <= evcnt_ff + 1'b1;
    end
  end

  // Outputs registered; forcing overrides only indications
  // Trip with start
  wire nxt_start = force_st || force_tr || state_ff == PST_START || state_ff == PST_TRIP;
  wire nxt_trip  = force_tr || state_ff == PST_TRIP;
  wire nxt_blk   = state_ff == PST_BLOCK_INDICATION;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= nxt_start;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      trip_ff <= 1'b0;
    end else begin
      trip_ff <= nxt_trip;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      blk_ff <= 1'b0;
    end else begin
      blk_ff <= nxt_blk;
    end
  end

  // Register reads
  pst_status_t status;
  assign status = '{start: start_ff, trip: trip_ff, block_indication: blk_ff, picked: picked_ff};

  wire [31:0] rd_mux =
    addr_in == A_CTRL    ? 32'(ctrl_ff)         :
    addr_in == A_PICKUP  ? 32'(pickup_level_ff) :
    addr_in == A_NOMINAL ? 32'(nominal_ff)      :
    addr_in == A_DELAY   ? 32'(delay_ff)        :
    addr_in == A_INVDLY  ? 32'(inv_dly_ff)      :
    addr_in == A_STATUS  ? 32'(status)          :
    addr_in == A_EVCNT   ? 32'(evcnt_ff)        : 32'h0000_0000;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata_out             = rdata_ff;
  assign curve_ieee_out        = ieee;
  assign inverse_time_mode_out = inv_mode;
  assign cycle_tick_out        = cycle_tick;
  assign start_out             = start_ff;
  assign trip_out              = trip_ff;
  assign block_indication_out  = blk_ff;
  assign hmi_notice_out        = hmi_ff;
  assign event_valid_out       = event_valid_ff;
  assign event_out             = event_ff;

endmodule : pst_stage

// >>> testbench.sv
// Self-checking bench for the protection stage core
`timescale 1ns/1ps
module testbench;
  import pst_pkg::*;
  logic              clk_in = 1'h0;
  logic              sys_rst_in = 1'h1;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [31:0]       wdata_in = '0;
  logic              wr_in = 1'h0;
  logic              rd_in = 1'h0;
  logic [31:0]       rdata_out;
  logic [MAG_W-1:0]  mag_req = '0;
  logic              blk_req = 1'h0;
  logic [1:0]        fault_type_in = 2'h2;
  logic [MAG_W-1:0]  measured_magnitude_in;
  logic              block_in;
  logic [DLY_W-1:0]  inverse_delay_in;
  logic              curve_ieee_out, inverse_time_mode_out, cycle_tick_out;
  logic              start_out, trip_out, block_indication_out;
  logic              hmi_notice_out, event_valid_out;
  pst_event_t        event_out;
  logic [31:0]       got;
  int                n_mismatch = 0;
  int                samples_checked = 0;
  logic [31:0]       rst_tbl [0:7] = '{32'h0, 32'h3d090, 32'h3e8, 32'h8,
                                       32'h0, 32'h0, 32'h0, 32'h0};

  always #10 clk_in = ~clk_in;

  pst_stage pst_stage_inst (.clk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .measured_magnitude_in, .fault_type_in, .block_in,
    .inverse_delay_in, .curve_ieee_out, .inverse_time_mode_out, .cycle_tick_out,
    .start_out, .trip_out, .block_indication_out, .hmi_notice_out,
    .event_valid_out, .event_out);
  pst_meas_model pst_meas_model_inst (.clk_in, .sys_rst_in, .mag_req_in(mag_req),
    .blk_req_in(blk_req), .mag_out(measured_magnitude_in), .blk_out(block_in),
    .inv_dly_out(inverse_delay_in));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'h1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'h0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd_in <= 1'h1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'h0;
    #1;
    d = rdata_out;
  endtask : bus_rd

  // One program cycle; block lands a cycle later than magnitude
  task automatic step(input logic [MAG_W-1:0] m, input logic b, input logic [2:0] e);
    @(posedge clk_in);
    mag_req <= m;
    blk_req <= b;
    do @(posedge clk_in); while (cycle_tick_out !== 1'h1);
    repeat (2) @(posedge clk_in);
    #1;
    chk({29'h0, start_out, trip_out, block_indication_out}, {29'h0, e});
  endtask : step

  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      bus_rd(4'(i), got);
      chk(got, rst_tbl[i]);
    end
    bus_wr(A_PICKUP, 32'h0);
    bus_rd(A_PICKUP, got);
    chk(got, 32'h1);
    bus_wr(A_NOMINAL, 32'h10);
    bus_rd(A_NOMINAL, got);
    chk(got, 32'h0c8);
    bus_wr(A_NOMINAL, 32'h3ffff);
    bus_rd(A_NOMINAL, got);
    chk(got, 32'h2710);
    bus_wr(A_NOMINAL, 32'h3e8);
    bus_wr(A_DELAY, 32'h7ffff);
    bus_rd(A_DELAY, got);
    chk(got, 32'h57e40);
    bus_wr(4'h7, 32'h5a);
    bus_rd(4'h7, got);
    chk(got, 32'h0);
    bus_wr(A_CTRL, 32'h34);
    repeat (3) @(posedge clk_in);
    chk({28'h0, curve_ieee_out, inverse_time_mode_out, start_out, trip_out}, 32'h0);
    bus_wr(A_CTRL, 32'h6);
    repeat (3) @(posedge clk_in);
    chk({30'h0, curve_ieee_out, inverse_time_mode_out}, 32'h3);
    bus_wr(A_CTRL, 32'h0);
    bus_wr(A_PICKUP, 32'h3e8);
  endtask : t_regs

  task automatic t_instant();
    bus_wr(A_DELAY, 32'h0);
    step(18'h005dc, 1'h0, 3'h6);
    step(18'h003d4, 1'h0, 3'h6);
    step(18'h003c0, 1'h0, 3'h0);
  endtask : t_instant

  task automatic t_block();
    bus_wr(A_DELAY, 32'h1);
    step(18'h005dc, 1'h1, 3'h4);
    step(18'h005dc, 1'h1, 3'h1);
    bus_rd(A_STATUS, got);
    chk(got, 32'h3);
    bus_rd(A_EVCNT, got);
    chk(got, 32'h1);
    chk({12'h0, event_out}, {12'h0, 18'h005dc, 2'h2});
    step(18'h0, 1'h0, 3'h0);
    step(18'h005dc, 1'h0, 3'h4);
    step(18'h005dc, 1'h0, 3'h6);
  endtask : t_block

  task automatic t_under();
    // Under direction, level in per unit
    bus_wr(A_CTRL, 32'h41);
    bus_wr(A_PICKUP, 32'h1f4);
    bus_wr(A_DELAY, 32'h0);
    step(18'h00258, 1'h0, 3'h0);
    step(18'h00190, 1'h0, 3'h6);
    step(18'h001fe, 1'h0, 3'h6);
  endtask : t_under

  task automatic summarize();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    t_regs();
    t_instant();
    t_block();
    t_under();
    summarize();
  end

  // About ten 5 ms cycles needed; allow 24 (120 ms)
  initial begin
    #120_000_000;
    n_mismatch++;
    summarize();
  end
endmodule : testbench

bind pst_stage pst_monitor pst_monitor_inst (.clk_in, .sys_rst_in, .cycle_tick_out,
  .start_out, .trip_out, .block_indication_out, .hmi_notice_out, .event_valid_out,
  .event_out, .curve_ieee_out, .inverse_time_mode_out);
